// ### shared/tsm_regs.svh
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH

// clock and timing
`define TSM_CLK_HZ 20_000_000
`define TSM_NV_WRITE_MS 10
`define TSM_NV_WRITE_CYC ((`TSM_CLK_HZ / 1000) * `TSM_NV_WRITE_MS)
`define TSM_PD_HOLD_S 10
`define TSM_PD_HOLD_CYC (`TSM_CLK_HZ * `TSM_PD_HOLD_S)
`define TSM_WAKE_PULSES 5'h10

// conversion constants (plain defaults, trimmed per part)
`define TSM_BASE_TEMP 8'hC9
`define TSM_MAX_TEMP 8'h7D
`define TSM_BASE_COUNT 9'h0_0C8
`define TSM_SLOPE_INIT 9'h0_064
`define TSM_SLOPE_STEP 9'h0_001
`define TSM_GATE_TICKS 16'h0_400

// commands
`define TSM_CMD_START 8'hEE
`define TSM_CMD_STOP 8'h22

// status/configuration byte
`define TSM_CFG_DONE 7
`define TSM_CFG_ONE 6
`define TSM_CFG_NVB 5
`define TSM_CFG_OVER 4
`define TSM_CFG_UNDER 3
`define TSM_CFG_PWRUP 2
`define TSM_CFG_POL 1
`define TSM_CFG_SINGLE 0

// delivered contents of nonvolatile storage
`define TSM_NV_UPPER_INIT 8'h00
`define TSM_NV_LOWER_INIT 8'h00
`define TSM_NV_PWRUP_INIT 1'b0
`define TSM_NV_POL_INIT 1'b0
`define TSM_NV_SINGLE_INIT 1'b0

`endif

// ### shared/tsm_pkg.sv
package tsm_pkg;
  typedef enum logic {TSM_MODE_HOST, TSM_MODE_THERMO} tsm_mode_t;
  typedef enum logic [1:0] {TSM_WK_IDLE, TSM_WK_ARMED, TSM_WK_COUNT} tsm_wake_t;
  typedef enum logic {TSM_CV_IDLE, TSM_CV_RUN} tsm_cv_state_t;
endpackage

// ### shared/tsm_conv_if.sv
`timescale 1ns/1ps
interface tsm_conv_if;
  logic start;
  logic lo_tick;
  logic hi_tick;
  logic busy;
  logic done;
  logic [7:0] result;
  logic [8:0] count_rem;
  logic [8:0] slope;
  modport ctl (output start, output lo_tick, output hi_tick,
    input busy, input done, input result, input count_rem, input slope);
  modport conv (input start, input lo_tick, input hi_tick,
    output busy, output done, output result, output count_rem, output slope);
endinterface

// ### rtl/tsm_conv.sv
`timescale 1ns/1ps
`include "tsm_regs.svh"
module tsm_conv
  import tsm_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rstn, // sync reset, active low
  tsm_conv_if.conv cif // control side
);
  tsm_cv_state_t state_q;
  logic [8:0] cnt_q;
  logic [8:0] slope_q;
  logic [7:0] acc_q;
  logic [15:0] gate_q;
  logic done_q;
  logic [7:0] result_q;
  logic [8:0] rem_q;
  logic gate_close;

  assign gate_close = cif.hi_tick && (gate_q == 16'h0_001);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= TSM_CV_IDLE;
      cnt_q <= 9'h0_000;
      slope_q <= `TSM_SLOPE_INIT;
      acc_q <= `TSM_BASE_TEMP;
      gate_q <= 16'h0_000;
      done_q <= 1'b0;
      result_q <= `TSM_BASE_TEMP;
      rem_q <= 9'h0_000;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        TSM_CV_IDLE: begin
          if (cif.start) begin
            cnt_q <= `TSM_BASE_COUNT;
            acc_q <= `TSM_BASE_TEMP;
            slope_q <= `TSM_SLOPE_INIT;
            gate_q <= `TSM_GATE_TICKS;
            state_q <= TSM_CV_RUN;
          end
        end
        TSM_CV_RUN: begin
          // counter on low-tc ticks, gate on high-tc ticks
          if (gate_close) begin
            // gate shut first: reading is final
            result_q <= acc_q;
            rem_q <= cnt_q;
            done_q <= 1'b1;
            state_q <= TSM_CV_IDLE;
          end else begin
            if (cif.hi_tick) begin
              gate_q <= gate_q - 16'h0_001;
            end
            if (cif.lo_tick) begin
              if (cnt_q <= 9'h0_001) begin
                // zero reached inside gate: one degree up (held at TSM_MAX_TEMP), reload
                if (acc_q != `TSM_MAX_TEMP) begin
                  acc_q <= acc_q + 8'h01;
                end
                cnt_q <= slope_q;
                slope_q <= slope_q + `TSM_SLOPE_STEP;
              end else begin
                cnt_q <= cnt_q - 9'h0_001;
              end
            end
          end
        end
        default: state_q <= TSM_CV_IDLE;
      endcase
    end
  end

  assign cif.busy = (state_q == TSM_CV_RUN);
  assign cif.done = done_q;
  assign cif.result = result_q;
  assign cif.count_rem = rem_q;
  assign cif.slope = slope_q;
endmodule

// ### rtl/tsm_top.sv
`timescale 1ns/1ps
`include "tsm_regs.svh"
module tsm_top
  import tsm_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYC = `TSM_NV_WRITE_CYC, // nonvolatile write time
  parameter int unsigned PD_HOLD_CYC = `TSM_PD_HOLD_CYC // power-down hold time
) (
  input wire logic clk, // 20 MHz clock
  input wire logic rstn, // sync reset, active low (power cycle)
  input wire logic factory_rstn, // sync, active low: nv to delivered state
  input wire logic vdd_low, // pin: supply pulled to 0 V
  input wire logic dq_i, // pin: data line level
  output logic dq_o, // data line output value (always low)
  output logic dq_oe_n, // data line enable, low while pulling low
  output logic dq_rx, // synchronised line level for slot logic
  input wire logic bus_pull_low, // slot logic wants line low
  input wire logic lo_osc, // pin: low temp-co oscillator
  input wire logic hi_osc, // pin: high temp-co oscillator
  input wire logic cmd_valid, // command strobe
  input wire logic [7:0] cmd_code, // command byte
  input wire logic wr_upper, // write upper trip strobe
  input wire logic wr_lower, // write lower trip strobe
  input wire logic wr_cfg, // write configuration strobe
  input wire logic [7:0] wr_data, // write data
  output logic [7:0] temp_out, // last temperature reading
  output logic [8:0] count_out, // counter remainder
  output logic [8:0] slope_out, // slope accumulator
  output logic [7:0] upper_trip_point, // upper trip point
  output logic [7:0] lower_trip_point, // lower trip point
  output logic [7:0] cfg_out, // configuration/status byte
  output logic host_mode, // host-bus mode active
  output logic standby, // no conversion running
  output logic powered_down // held off by long low
);
  tsm_conv_if cif ();

  // pin synchronisers: first stage feeds only the second
  logic [1:0] vdd_s_q, dq_s_q, lo_s_q, hi_s_q;
  logic lo_d_q, hi_d_q, dq_d_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      vdd_s_q <= 2'h0;
      dq_s_q <= 2'h3;
      lo_s_q <= 2'h0;
      hi_s_q <= 2'h0;
      lo_d_q <= 1'b0;
      hi_d_q <= 1'b0;
      dq_d_q <= 1'b1;
    end else begin
      vdd_s_q <= {vdd_s_q[0], vdd_low};
      dq_s_q <= {dq_s_q[0], dq_i};
      lo_s_q <= {lo_s_q[0], lo_osc};
      hi_s_q <= {hi_s_q[0], hi_osc};
      lo_d_q <= lo_s_q[1];
      hi_d_q <= hi_s_q[1];
      dq_d_q <= dq_s_q[1];
    end
  end
  logic vdd_lo, dq_hi, dq_fall;
  assign vdd_lo = vdd_s_q[1];
  assign dq_hi = dq_s_q[1];
  assign dq_fall = dq_d_q && !dq_s_q[1];
  assign dq_rx = dq_s_q[1];
  assign cif.lo_tick = lo_s_q[1] && !lo_d_q;
  assign cif.hi_tick = hi_s_q[1] && !hi_d_q;

  // nonvolatile storage: survives rstn, only factory_rstn restores it
  logic [7:0] nv_upper_q, nv_lower_q;
  logic nv_over_q, nv_under_q, nv_pwrup_q, nv_pol_q, nv_single_q;
  logic [27:0] nv_cnt_q;
  logic nv_busy;
  logic nv_wr;
  logic over_set, under_set;
  logic done_ev;
  logic [7:0] res;
  assign nv_busy = (nv_cnt_q != 28'h000_0000);
  // writes while busy are dropped to protect the stored data
  assign nv_wr = (wr_upper || wr_lower || wr_cfg) && !nv_busy && !powered_down;

  always_ff @(posedge clk) begin
    if (!factory_rstn) begin
      nv_upper_q <= `TSM_NV_UPPER_INIT;
      nv_lower_q <= `TSM_NV_LOWER_INIT;
      nv_pwrup_q <= `TSM_NV_PWRUP_INIT;
      nv_pol_q <= `TSM_NV_POL_INIT;
      nv_single_q <= `TSM_NV_SINGLE_INIT;
    end else if (nv_wr && host_mode) begin
      // trips taken as signed degree bytes
      if (wr_upper) begin
        nv_upper_q <= wr_data;
      end
      if (wr_lower) begin
        nv_lower_q <= wr_data;
      end
      if (wr_cfg) begin
        nv_pwrup_q <= wr_data[`TSM_CFG_PWRUP]; // only path to new mode
        nv_pol_q <= wr_data[`TSM_CFG_POL];
        nv_single_q <= wr_data[`TSM_CFG_SINGLE];
      end
    end
  end

  // sticky flags: a new event beats a clearing write
  always_ff @(posedge clk) begin
    if (!factory_rstn) begin
      nv_over_q <= 1'b0;
      nv_under_q <= 1'b0;
    end else begin
      if (over_set) begin
        nv_over_q <= 1'b1;
      end else if (nv_wr && host_mode && wr_cfg) begin
        nv_over_q <= wr_data[`TSM_CFG_OVER];
      end
      if (under_set) begin
        nv_under_q <= 1'b1;
      end else if (nv_wr && host_mode && wr_cfg) begin
        nv_under_q <= wr_data[`TSM_CFG_UNDER];
      end
    end
  end

  // write pacing timer, counted as one write time from the strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nv_cnt_q <= 28'h000_0000;
    end else if (nv_wr && host_mode) begin
      nv_cnt_q <= 28'(NV_WRITE_CYC);
    end else if (nv_busy) begin
      nv_cnt_q <= nv_cnt_q - 28'h000_0001;
    end
  end

  // power-up mode capture one cycle after release, then wake sequence
  tsm_mode_t mode_q;
  tsm_wake_t wk_q;
  logic boot_q;
  logic [4:0] pulse_q;
  logic [27:0] pd_cnt_q;
  logic pd_q;
  logic wake_hit;
  assign wake_hit = (wk_q == TSM_WK_COUNT) && dq_fall
    && (pulse_q == (`TSM_WAKE_PULSES - 5'h01));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      boot_q <= 1'b0;
      mode_q <= TSM_MODE_HOST;
    end else if (!boot_q || pd_q) begin
      boot_q <= !pd_q;
      // stored bit picks the mode
      mode_q <= nv_pwrup_q ? TSM_MODE_THERMO : TSM_MODE_HOST;
    end else if (wake_hit && nv_pwrup_q) begin
      // toggles only a live mode, stored bit untouched
      mode_q <= (mode_q == TSM_MODE_THERMO) ? TSM_MODE_HOST : TSM_MODE_THERMO;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wk_q <= TSM_WK_IDLE;
      pulse_q <= 5'h00;
    end else begin
      case (wk_q)
        TSM_WK_IDLE: begin
          pulse_q <= 5'h00;
          if (vdd_lo && dq_hi) begin
            wk_q <= TSM_WK_ARMED;
          end
        end
        TSM_WK_ARMED: begin
          if (!vdd_lo) begin
            wk_q <= TSM_WK_COUNT;
          end
        end
        TSM_WK_COUNT: begin
          if (dq_fall) begin
            pulse_q <= pulse_q + 5'h01;
            if (wake_hit) begin
              wk_q <= TSM_WK_IDLE;
            end
          end
        end
        default: wk_q <= TSM_WK_IDLE;
      endcase
    end
  end

  // long low on both supply and line powers down
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pd_cnt_q <= 28'h000_0000;
      pd_q <= 1'b0;
    end else if (vdd_lo && !dq_hi) begin
      if (pd_cnt_q >= 28'(PD_HOLD_CYC)) begin
        pd_q <= 1'b1;
      end else begin
        pd_cnt_q <= pd_cnt_q + 28'h000_0001;
      end
    end else begin
      pd_cnt_q <= 28'h000_0000;
      if (!vdd_lo) begin
        pd_q <= 1'b0;
      end
    end
  end

  // conversion control
  logic run_q;
  logic single_q;
  logic done_bit_q;
  logic start_q;
  logic is_host;
  assign is_host = (mode_q == TSM_MODE_HOST);
  assign done_ev = cif.done;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      run_q <= 1'b0;
      single_q <= 1'b0;
      done_bit_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (pd_q || !boot_q) begin
        run_q <= 1'b0;
        single_q <= 1'b0;
      end else if (!is_host) begin
        run_q <= 1'b1; // single bit ignored here
        single_q <= 1'b0;
      end else if (cmd_valid && cmd_code == `TSM_CMD_START) begin
        if (nv_single_q) begin
          run_q <= 1'b0;
          // a running conversion is left alone, its done report still due
          if (!cif.busy) begin
            single_q <= 1'b1; // one conversion only
            done_bit_q <= 1'b0;
            start_q <= 1'b1;
          end
        end else begin
          run_q <= 1'b1;
        end
      end else if (cmd_valid && cmd_code == `TSM_CMD_STOP) begin
        run_q <= 1'b0;
      end else if (single_q && done_ev) begin
        single_q <= 1'b0; // back to standby
        done_bit_q <= 1'b1;
      end
      if (run_q && !cif.busy && !start_q && !pd_q) begin
        start_q <= 1'b1;
      end
    end
  end
  assign cif.start = start_q;

  // reading kept until the next completion
  logic [7:0] temp_q;
  logic [8:0] count_q;
  logic therm_q;
  assign res = cif.result;
  assign over_set = done_ev && ($signed(res) > $signed(nv_upper_q));
  assign under_set = done_ev && ($signed(res) < $signed(nv_lower_q));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      temp_q <= `TSM_BASE_TEMP;
      count_q <= 9'h0_000;
      therm_q <= 1'b0;
    end else if (done_ev) begin
      temp_q <= res;
      count_q <= cif.count_rem;
      // decided only at completion, holds between trips
      if (over_set) begin
        therm_q <= 1'b1;
      end else if (under_set) begin
        therm_q <= 1'b0;
      end
    end
  end

  // open-drain line: release means high through the pull-up
  logic oe_n_q;
  logic level;
  assign level = therm_q ? nv_pol_q : !nv_pol_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      oe_n_q <= 1'b1;
    end else if (pd_q) begin
      oe_n_q <= 1'b1;
    end else if (!is_host) begin
      oe_n_q <= level; // line is the thermostat output
    end else begin
      oe_n_q <= !bus_pull_low;
    end
  end

  assign dq_o = 1'b0;
  assign dq_oe_n = oe_n_q;
  assign temp_out = temp_q;
  assign count_out = count_q;
  assign slope_out = cif.slope;
  assign upper_trip_point = nv_upper_q;
  assign lower_trip_point = nv_lower_q;
  // busy bit live from the write timer
  // done reads 0 outside one-shot
  assign cfg_out = {(nv_single_q && done_bit_q), 1'b1, nv_busy, nv_over_q,
    nv_under_q, nv_pwrup_q, nv_pol_q, nv_single_q};
  assign host_mode = is_host && boot_q;
  assign standby = !cif.busy;
  assign powered_down = pd_q;

  tsm_conv u_conv (
    .clk(clk),
    .rstn(rstn),
    .cif(cif)
  );
endmodule

// ### tb/tsm_far_model.sv
`timescale 1ns/1ps
module tsm_far_model (
  input wire logic clk, // bench clock
  input wire logic dq_oe_n, // device enable, low while pulling
  input wire logic host_low, // host pulls the line low
  output logic dq_line, // resolved line level
  output logic lo_osc, // low temp-co oscillator
  output logic hi_osc // high temp-co oscillator
);
  logic [4:0] div_q = 5'h00;
  // pull-up: high unless a party pulls
  assign dq_line = !(host_low || !dq_oe_n);
  always_ff @(posedge clk) begin
    div_q <= div_q + 5'h01;
  end
  // gate tick every 8 cycles, count tick every 32: 256 counts per gate
  assign hi_osc = div_q[2];
  assign lo_osc = div_q[4];
endmodule

// ### tb/tsm_top_asserts.sv
`timescale 1ns/1ps
module tsm_top_asserts #(
  parameter int unsigned NV_WRITE_CYC = 20, // nonvolatile write time
  parameter int unsigned PD_HOLD_CYC = 50 // power-down hold time
) (
  input wire logic clk, // clock
  input wire logic rstn, // sync reset, active low
  input wire logic vdd_low, // supply low pin
  input wire logic dq_i, // line level
  input wire logic dq_oe_n, // line enable
  input wire logic bus_pull_low, // slot logic pull
  input wire logic cmd_valid, // command strobe
  input wire logic [7:0] cmd_code, // command byte
  input wire logic wr_upper, // upper trip write
  input wire logic wr_cfg, // config write
  input wire logic [7:0] upper_trip_point, // upper trip
  input wire logic [7:0] cfg_out, // config byte
  input wire logic host_mode, // host-bus mode
  input wire logic standby, // converter idle
  input wire logic powered_down // held off
);
  logic [31:0] busy_cnt_q;
  logic [31:0] idle_cnt_q;
  logic pd_cond;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  assign pd_cond = vdd_low && !dq_i;
  always_ff @(posedge clk) begin
    if (!rstn || !cfg_out[5]) busy_cnt_q <= '0;
    else busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
  end
  // thermostat converter may pause while supply is low
  always_ff @(posedge clk) begin
    if (!rstn || host_mode || !standby || powered_down || vdd_low) idle_cnt_q <= '0;
    else idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
  end
  sequence write_taken;
    wr_cfg && host_mode && !powered_down && !cfg_out[5];
  endsequence
  sequence start_taken;
    cmd_valid && cmd_code == 8'hEE && host_mode && !powered_down && cfg_out[0];
  endsequence
  sequence done_rise;
    cfg_out[0] && $rose(cfg_out[7]);
  endsequence
  nvb_rise_a: assert property (write_taken |-> ##[1:2] cfg_out[5])
    else $error("busy bit did not rise");
  nvb_len_a: assert property (cfg_out[5] |-> busy_cnt_q < NV_WRITE_CYC)
    else $error("nonvolatile write too long");
  trip_keep_a: assert property ($changed(upper_trip_point) |-> $past(wr_upper))
    else $error("upper trip changed without write");
  pwrup_keep_a: assert property ($changed(cfg_out[2]) |-> $past(wr_cfg))
    else $error("power-up mode changed without write");
  host_line_a: assert property (host_mode && $past(host_mode) && !powered_down
    && !$past(powered_down) |-> dq_oe_n == !$past(bus_pull_low))
    else $error("line enable not from slot logic");
  start_a: assert property (start_taken |-> ##[1:3] (!cfg_out[7] && !standby))
    else $error("one-shot start not seen");
  oneshot_end_a: assert property (done_rise |-> standby)
    else $error("no standby after one-shot");
  done_zero_a: assert property (cfg_out[7] |-> cfg_out[0])
    else $error("done bit set in continuous mode");
  pd_entry_a: assert property ($rose(powered_down) |-> $past(pd_cond, 5)
    && $past(pd_cond, 40))
    else $error("power-down without long low");
  therm_conv_a: assert property (idle_cnt_q < 8)
    else $error("thermostat converter left idle");
endmodule
bind tsm_top tsm_top_asserts #(.NV_WRITE_CYC(NV_WRITE_CYC), .PD_HOLD_CYC(PD_HOLD_CYC))
  u_asserts (.clk, .rstn, .vdd_low, .dq_i, .dq_oe_n, .bus_pull_low, .cmd_valid, .cmd_code,
  .wr_upper, .wr_cfg, .upper_trip_point, .cfg_out, .host_mode, .standby, .powered_down);

// ### tb/tb_tsm_top.sv
`timescale 1ns/1ps
module tb_tsm_top;
  logic clk, rstn, factory_rstn, vdd_low, bus_pull_low, cmd_valid, host_low;
  logic wr_upper, wr_lower, wr_cfg, dq_line, dq_o, dq_oe_n, dq_rx, lo_osc, hi_osc;
  logic host_mode, standby, powered_down;
  logic [7:0] cmd_code, wr_data, temp_out, upper_trip_point, lower_trip_point, cfg_out;
  logic [8:0] count_out, slope_out;
  int failures, samples_checked;
  // 256 counts: past base count once, short of the next reload
  localparam logic [7:0] T_READ = 8'hCA;
  tsm_top #(.NV_WRITE_CYC(20), .PD_HOLD_CYC(50)) u_dut (.clk(clk), .rstn(rstn),
    .factory_rstn(factory_rstn), .vdd_low(vdd_low), .dq_i(dq_line), .dq_o(dq_o),
    .dq_oe_n(dq_oe_n), .dq_rx(dq_rx), .bus_pull_low(bus_pull_low), .lo_osc(lo_osc),
    .hi_osc(hi_osc), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .wr_upper(wr_upper),
    .wr_lower(wr_lower), .wr_cfg(wr_cfg), .wr_data(wr_data), .temp_out(temp_out),
    .count_out(count_out), .slope_out(slope_out), .upper_trip_point(upper_trip_point),
    .lower_trip_point(lower_trip_point), .cfg_out(cfg_out), .host_mode(host_mode),
    .standby(standby), .powered_down(powered_down));
  tsm_far_model u_far (.clk(clk), .dq_oe_n(dq_oe_n), .host_low(host_low),
    .dq_line(dq_line), .lo_osc(lo_osc), .hi_osc(hi_osc));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checked %0d, bad %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return standby;
      1: return cfg_out[7];
      3: return cfg_out[3];
      default: return dq_oe_n;
    endcase
  endfunction
  task automatic wait_for(input int s);
    for (int i = 0; i < 12000 && pick(s) !== 1'b1; i++) tick(1);
    chkb(pick(s), 1'b1);
  endtask
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    {wr_upper, wr_lower, wr_cfg} = sel;
    wr_data = d;
    tick(1);
    {wr_upper, wr_lower, wr_cfg} = 3'b000;
    tick(24);
  endtask
  task automatic cmd(input logic [7:0] c);
    cmd_valid = 1'b1;
    cmd_code = c;
    tick(1);
    cmd_valid = 1'b0;
    // one idle edge keeps back-to-back strobes apart
    tick(1);
  endtask
  task automatic wake;
    vdd_low = 1'b1;
    tick(6);
    vdd_low = 1'b0;
    tick(4);
    repeat (16) begin
      host_low = 1'b1;
      tick(4);
      host_low = 1'b0;
      tick(4);
    end
    tick(6);
  endtask
  task automatic t_reset;
    chk(temp_out, 8'hC9);
    chkb(host_mode, 1'b1);
    chk(cfg_out, 8'h40);
    bus_pull_low = 1'b1;
    tick(3);
    chkb(dq_oe_n, 1'b0);
    chkb(dq_rx, 1'b0);
    chkb(dq_o, 1'b0);
    bus_pull_low = 1'b0;
    tick(3);
    chkb(dq_oe_n, 1'b1);
    chkb(dq_rx, 1'b1);
    $display("reset test ends");
  endtask
  task automatic t_nv;
    wr_cfg = 1'b1;
    wr_data = 8'h01;
    tick(1);
    wr_cfg = 1'b0;
    wr_upper = 1'b1; // overlapping write, meant to be dropped
    wr_data = 8'h55;
    tick(1);
    wr_upper = 1'b0;
    chkb(cfg_out[5], 1'b1);
    chkb(cfg_out[0], 1'b1);
    tick(22);
    chkb(cfg_out[5], 1'b0);
    chk(upper_trip_point, 8'h00);
    $display("nonvolatile test ends");
  endtask
  task automatic t_oneshot;
    cmd(8'hEE);
    tick(3);
    chkb(cfg_out[7], 1'b0);
    chkb(standby, 1'b0);
    // restart and stop while running must not cancel the done report
    cmd(8'hEE);
    cmd(8'h22);
    wait_for(1);
    tick(1);
    chk(temp_out, T_READ);
    // counter reloaded once from the slope, which then stepped once
    chkb((count_out != 9'h000) && (count_out < 9'h064), 1'b1);
    chkb(slope_out == 9'h065, 1'b1);
    chkb(standby, 1'b1);
    $display("one-shot test ends");
  endtask
  task automatic t_cont;
    logic seen;
    seen = 1'b0;
    wr(3'b001, 8'h00);
    cmd(8'hEE);
    repeat (9000) begin
      tick(1);
      if (cfg_out[7] !== 1'b0) seen = 1'b1;
    end
    chkb(seen, 1'b0);
    chk(temp_out, T_READ);
    cmd(8'h22);
    wait_for(0);
    tick(100);
    chkb(standby, 1'b1);
    $display("continuous test ends");
  endtask
  task automatic t_thermo;
    wr(3'b100, 8'hC9);
    wr(3'b010, 8'hC9);
    wr(3'b001, 8'h06);
    chk(lower_trip_point, 8'hC9);
    rstn = 1'b0;
    tick(3);
    rstn = 1'b1;
    tick(5);
    chkb(host_mode, 1'b0);
    chkb(dq_oe_n, 1'b0);
    wait_for(2);
    chk(temp_out, T_READ);
    chkb(cfg_out[4], 1'b1);
    wr(3'b100, 8'h00);
    chk(upper_trip_point, 8'hC9);
    $display("thermostat test ends");
  endtask
  task automatic t_wake;
    wake();
    chkb(host_mode, 1'b1);
    chkb(cfg_out[2], 1'b1);
    wr(3'b110, 8'hCB);
    chk(upper_trip_point, 8'hCB);
    chk(lower_trip_point, 8'hCB);
    // reading now sits below both trips: under flag must set
    wait_for(3);
    wake();
    chkb(host_mode, 1'b0);
    chkb(dq_oe_n, 1'b0);
    vdd_low = 1'b1;
    host_low = 1'b1;
    tick(70);
    chkb(powered_down, 1'b1);
    vdd_low = 1'b0;
    host_low = 1'b0;
    tick(10);
    chkb(powered_down, 1'b0);
    chkb(host_mode, 1'b0);
    $display("wake test ends");
  endtask
  initial begin
    {rstn, factory_rstn, vdd_low, bus_pull_low, cmd_valid, host_low} = 6'h00;
    {wr_upper, wr_lower, wr_cfg} = 3'b000;
    cmd_code = 8'h00;
    wr_data = 8'h00;
    failures = 0;
    samples_checked = 0;
    tick(12);
    rstn = 1'b1;
    factory_rstn = 1'b1;
    tick(3);
    t_reset();
    t_nv();
    t_oneshot();
    t_cont();
    t_thermo();
    t_wake();
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
